// File: bnvmp_pkg.sv
// package for the bytewide nonvolatile memory port host controller
// assumes a single 250 MHz clock; timing figures become cycle counts here
//
// Overview of operation
// [R1] device starts each cycle and latches address on chip select falling edge
// [R2] device finishes the internal cycle even if chip select rises early
// [R3] read data valid only after the access time from cycle start
// [R4] address ignored after latch; host may change it after hold time
// [R5] device drives bus in reads only with output drive low and data valid
// [R6] device floats data lines while output drive is high
// [R7] writes by chip select or write strobe both use latched address
// [R8] write strobe low at chip select fall makes the whole cycle a write
// [R9] write strobe falling later starts cycle as read until it falls
// [R10] write ends at first rising edge of write strobe or chip select
// [R11] host keeps both strobes low at least until access time is met
// [R12] host holds write data stable during setup before write end
// [R13] writes complete in one bus cycle, no busy period or polling
// [R14] host keeps chip select high for at least the precharge time
// [R15] host never exceeds the maximum chip select low time
// [R16] each access costs one endurance cycle of its 8-byte row
// [R17] host makes a fresh chip select falling edge for every access
// [R18] host keeps chip select high while supply is below 4.5 V; the host only refuses new requests, an access under way runs to its end
// [R19] with chip select tied low, write strobe stays high in power cycling
// [R20] device never blocks accesses within the operating supply range
// [R21] 15-bit address selects one of 32,768 bytes
// [R22] 8-bit bidirectional data bus
// [R23] read data valid no later than 70 ns after chip select falls
// [R24] device floats data lines whenever chip select is high
package bnvmp_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_PS = 4000;

  // interface timing, figures in ns
  localparam int ACCESS_NS    = 70;
  localparam int PRECHARGE_NS = 60;
  localparam int ADDR_HOLD_NS = 15;
  localparam int OE_ACCESS_NS = 12;

  // least times round up to whole cycles
  localparam int ACCESS_CYC    = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_CYC      = (ADDR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OE_CYC        = (OE_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 6;

  // user request toward the controller
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bnvmp_req_t;

  // pins toward the memory, all strobes active low
  typedef struct packed {
    logic              chipSel_n;
    logic              writeStb_n;
    logic              outDrive_n;
    logic [ADDR_W-1:0] addrLines;
  } bnvmp_pins_t;

endpackage

// File: bnvmp_timer.sv
// down counter used to time each phase of a memory cycle
// assumes load and expiry are seen on the same clock as the controller
module bnvmp_timer #(
  parameter int W = 6
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  // status
  output logic              done
);

  logic [W-1:0] count_ff;

  // load wins over counting, so a phase restarts cleanly
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else if (load) begin
      count_ff <= loadVal;
    end else if (count_ff != '0) begin
      count_ff <= count_ff - W'(1);
    end
  end

  assign done = (count_ff == '0) && !load;

endmodule

// File: bnvmp_host.sv
// host controller driving the bytewide nonvolatile memory pins
// assumes the memory pins are synchronous to ref_clk and a board wire joins data lines
module bnvmp_host (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  // supply monitor: high while the supply is in tolerance
  input  wire logic                         supplyOk,
  // user request
  input  wire logic                         reqValid,
  output logic                              reqReady,
  input  wire bnvmp_pkg::bnvmp_req_t        req,
  // user answer
  output logic                              rspValid,
  output logic [bnvmp_pkg::DATA_W-1:0]      rspData,
  // memory pins
  output bnvmp_pkg::bnvmp_pins_t            pins,
  input  wire logic [bnvmp_pkg::DATA_W-1:0] dataIn,
  output logic [bnvmp_pkg::DATA_W-1:0]      dataOut,
  output logic                              dataOe_n
);

  typedef enum logic [2:0] {IDLE, SETUP, ACCESS, FINISH, PRECHG} bnvmp_state_t;

  bnvmp_state_t                    state_ff;
  bnvmp_state_t                    nxt_state;
  logic                            isWrite_ff;
  logic                            take;
  logic [bnvmp_pkg::DATA_W-1:0]    wdata_ff;
  logic                            chipSel_n_ff;
  logic                            writeStb_n_ff;
  logic                            outDrive_n_ff;
  logic [bnvmp_pkg::ADDR_W-1:0]    addrLines_ff;
  logic [bnvmp_pkg::DATA_W-1:0]    rspData_ff;
  logic                            rspValid_ff;
  logic                            driveData_ff;
  logic                            timerLoad;
  logic [bnvmp_pkg::CNT_W-1:0]     timerVal;
  logic                            timerDone;

  // one timer serves every phase, they never overlap
  bnvmp_timer #(.W(bnvmp_pkg::CNT_W)) phaseTimer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .load    (timerLoad),
    .loadVal (timerVal),
    .done    (timerDone)
  );

  // accept only in idle with supply good, so no access starts below 4.5 V; one already started still runs to its end
  assign reqReady = (state_ff == IDLE) && supplyOk; // R18

  // ready already implies idle, so this is the single take strobe
  assign take = reqReady && reqValid; // R18

  // phase sequencing
  always_comb begin
    nxt_state = state_ff;
    timerLoad = 1'b0;
    timerVal  = '0;
    unique case (state_ff)
      IDLE: begin
        if (reqValid && reqReady) begin
          nxt_state = SETUP;
        end
      end
      // address settles one cycle before chip select falls
      SETUP: begin
        nxt_state = ACCESS;
        timerLoad = 1'b1;
        timerVal  = bnvmp_pkg::CNT_W'(bnvmp_pkg::ACCESS_CYC + bnvmp_pkg::OE_CYC); // R11
      end
      // strobes stay low through access time, bounded so low time stays short
      ACCESS: begin
        if (timerDone) begin
          nxt_state = FINISH; // R15
        end
      end
      // strobes rise here, ending the write with data still driven
      FINISH: begin
        nxt_state = PRECHG;
        timerLoad = 1'b1;
        timerVal  = bnvmp_pkg::CNT_W'(bnvmp_pkg::PRECHARGE_CYC); // R14
      end
      PRECHG: begin
        if (timerDone) begin
          nxt_state = IDLE; // R13
        end
      end
      default: nxt_state = IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // request capture, held for the whole cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      isWrite_ff <= 1'b0;
      wdata_ff   <= '0;
    end else if (take) begin
      isWrite_ff <= req.write;
      wdata_ff   <= req.wdata;
    end
  end

  // address goes out at the take, a cycle ahead of chip select, and holds
  // until the next take, far beyond the hold time after the falling edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addrLines_ff <= '0;
    end else if (take) begin
      addrLines_ff <= req.addr; // R4
    end
  end

  // chip select low only while in access; it rises at finish and the
  // precharge then runs with it high, so every access gets a fresh fall
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chipSel_n_ff <= 1'b1;
    end else begin
      chipSel_n_ff <= (nxt_state != ACCESS); // R17
    end
  end

  // write strobe falls at the take, a cycle before chip select, so the
  // memory treats the cycle as a write from its start and never drives
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      writeStb_n_ff <= 1'b1;
    end else if (take) begin
      writeStb_n_ff <= !req.write; // R8
    end else if (state_ff == ACCESS && timerDone) begin
      writeStb_n_ff <= 1'b1; // R10
    end
  end

  // output drive only for reads, in the same window as chip select
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      outDrive_n_ff <= 1'b1;
    end else begin
      outDrive_n_ff <= !(nxt_state == ACCESS && !isWrite_ff);
    end
  end

  // host drives write data from the take until one cycle after the strobes
  // rise, so the data is still on the wire where the write ends
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      driveData_ff <= 1'b0;
    end else if (take) begin
      driveData_ff <= req.write; // R12
    end else if (state_ff == FINISH) begin
      driveData_ff <= 1'b0;
    end
  end

  // completion pulse for reads and writes alike, one cycle wide
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rspValid_ff <= 1'b0;
    end else begin
      rspValid_ff <= (state_ff == ACCESS) && timerDone; // R13
    end
  end

  // read data sampled at the last access cycle, after access plus output delay;
  // the margin costs a few cycles but covers a slow output turn-on
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rspData_ff <= '0;
    end else if (state_ff == ACCESS && timerDone && !isWrite_ff) begin
      rspData_ff <= dataIn; // R23
    end
  end

  assign pins     = '{chipSel_n:  chipSel_n_ff,
                      writeStb_n: writeStb_n_ff,
                      outDrive_n: outDrive_n_ff,
                      addrLines:  addrLines_ff};
  assign dataOut  = wdata_ff;
  assign dataOe_n = !driveData_ff;
  assign rspValid = rspValid_ff;
  assign rspData  = rspData_ff;

endmodule

// File: bnvmp_props.sv
// pin timing checker for the host controller
// bound to bnvmp_host; one clock, reset sync active low
module bnvmp_props (
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  // user side
  input wire logic                    supplyOk,
  input wire logic                    reqValid,
  input wire logic                    reqReady,
  input wire bnvmp_pkg::bnvmp_req_t   req,
  input wire logic                    rspValid,
  input wire logic [7:0]              rspData,
  // memory side
  input wire bnvmp_pkg::bnvmp_pins_t  pins,
  input wire logic [7:0]              dataIn,
  input wire logic [7:0]              dataOut,
  input wire logic                    dataOe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_supply; !supplyOk |-> !reqReady; endproperty
  a_supply: assert property (p_supply) else $error("request taken on low supply");
  property p_held;
    $fell(pins.chipSel_n) |-> !pins.chipSel_n[*8] ##1 !pins.chipSel_n[*8] ##1 !pins.chipSel_n[*2];
  endproperty
  a_held: assert property (p_held) else $error("chip select rose early");
  property p_max; $fell(pins.chipSel_n) |-> ##[17:22] $rose(pins.chipSel_n); endproperty
  a_max: assert property (p_max) else $error("chip select low too long");
  property p_prechg; $rose(pins.chipSel_n) |-> pins.chipSel_n[*8] ##1 pins.chipSel_n[*7]; endproperty
  a_prechg: assert property (p_prechg) else $error("precharge too short");
  property p_wdata; !pins.writeStb_n && $past(!pins.writeStb_n) |-> $stable(dataOut); endproperty
  a_wdata: assert property (p_wdata) else $error("write data moved");
  property p_drive; !pins.writeStb_n |-> !dataOe_n && pins.outDrive_n; endproperty
  a_drive: assert property (p_drive) else $error("write without bus drive");
  property p_csctl; $fell(pins.writeStb_n) |=> $fell(pins.chipSel_n); endproperty
  a_csctl: assert property (p_csctl) else $error("write strobe apart from chip select");
  property p_addr; !pins.chipSel_n && $past(!pins.chipSel_n) |-> $stable(pins.addrLines); endproperty
  a_addr: assert property (p_addr) else $error("address moved in cycle");
  property p_rsp; reqValid && reqReady |-> ##[20:26] rspValid; endproperty
  a_rsp: assert property (p_rsp) else $error("no answer in time");
  property p_fresh; rspValid |-> pins.chipSel_n; endproperty
  a_fresh: assert property (p_fresh) else $error("chip select left low");
  property p_wrend; $rose(pins.writeStb_n) |-> !dataOe_n; endproperty
  a_wrend: assert property (p_wrend) else $error("write data gone at write end");
  property p_rdbus; !pins.outDrive_n |-> pins.writeStb_n && dataOe_n; endproperty
  a_rdbus: assert property (p_rdbus) else $error("host drives bus in a read");
endmodule
bind bnvmp_host bnvmp_props bnvmp_props_inst (.ref_clk, .rst_n, .supplyOk, .reqValid, .reqReady,
  .req, .rspValid, .rspData, .pins, .dataIn, .dataOut, .dataOe_n);

// File: bnvmp_mem_model.sv
// behavioural model of the bytewide memory on the far side
// assumes pins change only on ref_clk edges
module bnvmp_mem_model (
  // clock
  input wire logic                    ref_clk,
  // pins
  input wire bnvmp_pkg::bnvmp_pins_t  pins,
  input wire logic [7:0]              bus,
  output logic [7:0]                  dq,
  output logic                        dqEn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:32767];
  logic [14:0] adr = '0;
  logic        wr = 1'b0;
  logic        csq = 1'b1;
  logic        weq = 1'b1;
  int          cnt = 0;
  // no supply lockout: every cycle is served
  always @(posedge ref_clk) begin
    csq <= pins.chipSel_n;
    weq <= pins.writeStb_n;
    if (csq && !pins.chipSel_n) begin
      adr <= pins.addrLines;
      wr  <= !pins.writeStb_n;
      cnt <= 0;
    end else cnt <= cnt + 1;
    if (!csq && !weq && (pins.chipSel_n || pins.writeStb_n)) mem[adr] <= bus;
  end
  // drive only once access time is met in a read
  assign dqEn = !pins.chipSel_n && !pins.outDrive_n && pins.writeStb_n && !wr
                && cnt >= bnvmp_pkg::ACCESS_CYC;
  assign dq = mem[adr];
endmodule

// File: test_bnvmp_host.sv
// self-checking bench for the host controller
// assumes the memory model answers on the shared data wire
module test_bnvmp_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0, supplyOk = 1, reqValid = 0;
  bnvmp_pkg::bnvmp_req_t  req = '0;
  bnvmp_pkg::bnvmp_pins_t pins;
  logic reqReady, rspValid, dataOe_n, dqEn;
  logic [7:0] rspData, dataOut, bus, dq, q, junk = 8'h5C;
  int mismatches = 0, samples_checked = 0;
  logic hung = 1'b0;
  always #2 ref_clk = ~ref_clk;
  // a floating wire must not look like valid data
  always @(posedge ref_clk) junk <= ~junk + 8'h3B;
  assign bus = !dataOe_n ? dataOut : dqEn ? dq : junk;
  bnvmp_host bnvmp_host_inst (.ref_clk, .rst_n, .supplyOk, .reqValid, .reqReady, .req,
    .rspValid, .rspData, .pins, .dataIn(bus), .dataOut, .dataOe_n);
  bnvmp_mem_model bnvmp_mem_model_inst (.ref_clk, .pins, .bus, .dq, .dqEn);
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // request held until taken, then bounded wait for the answer
  // a hang counts once, then later transfers are skipped on the way to the verdict
  task xfer(logic w, logic [14:0] a, logic [7:0] d);
    int i;
    if (hung) return;
    @(negedge ref_clk);
    reqValid = 1;
    req = '{w, a, d};
    for (i = 0; reqReady !== 1'b1 && i < 100; i++) @(negedge ref_clk);
    if (reqReady !== 1'b1) begin
      mismatches++;
      $display("wrong value reqReady exp 1 got %b", reqReady);
      hung = 1;
      reqValid = 0;
      return;
    end
    @(negedge ref_clk);
    reqValid = 0;
    for (i = 0; rspValid !== 1'b1 && i < 100; i++) @(negedge ref_clk);
    if (rspValid !== 1'b1) begin
      mismatches++;
      $display("wrong value rspValid exp 1 got %b", rspValid);
      hung = 1;
      return;
    end
    q = rspData;
  endtask
  task t_wr_rd;
    xfer(1, 15'h0000, 8'h5A);
    xfer(0, 15'h0000, 8'h00);
    chk("rd0", 8'h5A, q);
  endtask
  // ends and edges of rows at the top and bottom of the space
  task t_rows;
    logic [14:0] ad [3] = '{15'h7FF8, 15'h7FFF, 15'h0007};
    logic [7:0]  dv [3] = '{8'hC3, 8'h3C, 8'h96};
    foreach (ad[k]) xfer(1, ad[k], dv[k]);
    foreach (ad[k]) begin
      xfer(0, ad[k], 8'h00);
      chk("row", dv[k], q);
    end
  endtask
  // low supply from the last precharge on: a write held up once idle must not be taken nor land
  task t_supply;
    @(negedge ref_clk);
    supplyOk = 0;
    repeat (24) @(negedge ref_clk);
    reqValid = 1;
    req = '{1'b1, 15'h0000, 8'hA5};
    repeat (6) @(negedge ref_clk);
    chk("ready", 8'h00, {7'h0, reqReady});
    chk("cs", 8'h01, {7'h0, pins.chipSel_n});
    chk("oe", 8'h01, {7'h0, dataOe_n & pins.outDrive_n});
    chk("rsp", 8'h00, {7'h0, rspValid});
    reqValid = 0;
    supplyOk = 1;
    xfer(0, 15'h0000, 8'h00);
    chk("kept", 8'h5A, q);
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    rst_n = 1;
    t_wr_rd();
    t_rows();
    t_supply();
    close_out();
  end
endmodule
